// ===== common/csl_pkg.sv
// Purpose: Shared constants and types for the crosspoint serial loader.
// Assumes: One 100 MHz clock; the serial pins arrive from outside its domain.
// Notes:
`default_nettype none
package csl_pkg;
   localparam int CSL_ROWS        = 16;
   localparam int CSL_COLS        = 16;
   localparam int CSL_BITS        = CSL_ROWS * CSL_COLS;
   localparam int CSL_FIFO_DEPTH  = 8;
   localparam int CSL_CLK_HZ      = 100_000_000;
   localparam int CSL_SHIFT_MIN_HZ  = 20_000;
   localparam int CSL_LOAD_MAX_MS   = 5;
   // Longest times round down
   localparam int CSL_SHIFT_GAP_CYC = CSL_CLK_HZ / CSL_SHIFT_MIN_HZ;
   localparam int CSL_LOAD_MAX_CYC  = (CSL_CLK_HZ / 1000) * CSL_LOAD_MAX_MS;
   localparam int CSL_TMR_W         = 20;
   localparam logic [CSL_BITS-1:0] CSL_REG_RESET = '0;

   typedef struct packed {
      logic shiftClk;
      logic shiftDataIn;
      logic loadStrobe_b;
   } csl_pins_t;

   typedef struct packed {
      logic dataBit;
   } csl_word_t;

   localparam csl_pins_t CSL_PINS_IDLE = '{shiftClk: 1'b0, shiftDataIn: 1'b0,
                                           loadStrobe_b: 1'b1};
endpackage
`default_nettype wire

// ===== src/csl_fifo.sv
// Purpose: Small FIFO between the serial edge sampler and the shift register.
// Assumes: Single clock, synchronous active-low reset.
// Notes: Full and empty come from an occupancy count, so they are exact.
`default_nettype none
module csl_fifo
   import csl_pkg::*;
#(
   parameter int WIDTH = 1,
   parameter int DEPTH = CSL_FIFO_DEPTH
) (
   input  wire logic             clk,
   input  wire logic             rst_b,
   input  wire logic             inValid,
   output logic                  inReady,
   input  wire logic [WIDTH-1:0] inData,
   output logic                  outValid,
   input  wire logic             outReady,
   output logic      [WIDTH-1:0] outData
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);
   localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
   localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);

   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0]    wrPtr_r;
   logic [AW-1:0]    rdPtr_r;
   logic [CW-1:0]    count_r;
   logic             doPush;
   logic             doPop;

   assign inReady  = (count_r != FULL_CNT);
   assign outValid = (count_r != '0);
   assign outData  = mem_r[rdPtr_r];
   assign doPush   = inValid && inReady;
   assign doPop    = outValid && outReady;

   always_ff @(posedge clk) begin
      if (doPush) begin
         mem_r[wrPtr_r] <= inData;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         wrPtr_r <= '0;
      end else if (doPush) begin
         wrPtr_r <= (wrPtr_r == LAST_PTR) ? '0 : wrPtr_r + 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         rdPtr_r <= '0;
      end else if (doPop) begin
         rdPtr_r <= (rdPtr_r == LAST_PTR) ? '0 : rdPtr_r + 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         count_r <= '0;
      end else if (doPush && !doPop) begin
         count_r <= count_r + 1'b1;
      end else if (doPop && !doPush) begin
         count_r <= count_r - 1'b1;
      end
   end

   property p_full_refuses;
      @(posedge clk) disable iff (!rst_b)
         (count_r == FULL_CNT) && !doPop |=> !inReady && (count_r == FULL_CNT);
   endproperty
   a_full_refuses: assert property (p_full_refuses) else $error("full fifo took data");
endmodule
`default_nettype wire

// ===== src/csl_loader.sv
// Purpose: Serial loader and static latches for a 16 by 16 crosspoint matrix.
// Assumes: Serial clock, data and strobe come from pins and are synchronised here.
// Notes: The serial clock must be well below half the system clock for edge detection.
`default_nettype none
module csl_loader
   import csl_pkg::*;
#(
   parameter int SHIFT_GAP_CYC = CSL_SHIFT_GAP_CYC,
   parameter int LOAD_MAX_CYC  = CSL_LOAD_MAX_CYC
) (
   input  wire logic                clk,
   input  wire logic                rst_b,
   input  wire logic                shiftClk,
   input  wire logic                shiftDataIn,
   input  wire logic                loadStrobe_b,
   output logic                     shiftDataOut,
   output logic      [CSL_BITS-1:0] switchClosed,
   output logic                     shiftTooSlow,
   output logic                     loadLate
);
   localparam logic [CSL_TMR_W-1:0] GAP_LIMIT  = CSL_TMR_W'(SHIFT_GAP_CYC);
   localparam logic [CSL_TMR_W-1:0] LOAD_LIMIT = CSL_TMR_W'(LOAD_MAX_CYC);

   csl_pins_t         pinMeta_r;
   csl_pins_t         pinSync_r;
   csl_pins_t         pinPrev_r;
   logic              riseEdge;
   logic              pending_r;
   csl_word_t         pendWord_r;
   csl_word_t         pushWord;
   logic              pushValid;
   logic              pushReady;
   logic              popValid;
   logic              popReady;
   csl_word_t         popWord;
   logic              shiftNow;
   logic              strobeLow;
   logic [CSL_BITS-1:0] shiftReg_r;
   logic [CSL_BITS-1:0] latch_r;
   logic [CSL_TMR_W-1:0] gapTmr_r;
   logic [CSL_TMR_W-1:0] loadTmr_r;
   logic              loading_r;
   logic              armed_r;

   // Two-stage synchronisers on every pin
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         pinMeta_r <= CSL_PINS_IDLE;
      end else begin
         pinMeta_r <= '{shiftClk: shiftClk, shiftDataIn: shiftDataIn,
                        loadStrobe_b: loadStrobe_b};
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         pinSync_r <= CSL_PINS_IDLE;
         pinPrev_r <= CSL_PINS_IDLE;
      end else begin
         pinSync_r <= pinMeta_r;
         pinPrev_r <= pinSync_r;
      end
   end

   // Data travels beside the clock through equal stages, so setup and hold carry over
   assign riseEdge  = pinSync_r.shiftClk && !pinPrev_r.shiftClk;
   assign strobeLow = !pinSync_r.loadStrobe_b;

   // An edge that meets a full FIFO is parked; a second edge while parked is lost
   assign pushValid = riseEdge || pending_r;
   assign pushWord  = pending_r ? pendWord_r : csl_word_t'{dataBit: pinSync_r.shiftDataIn};

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         pending_r  <= 1'b0;
         pendWord_r <= '{dataBit: 1'b0};
      end else if (pushValid && !pushReady) begin
         pending_r  <= 1'b1;
         pendWord_r <= pushWord;
      end else if (pushReady) begin
         pending_r  <= 1'b0;
      end
   end

   csl_fifo #(
      .WIDTH ($bits(csl_word_t)),
      .DEPTH (CSL_FIFO_DEPTH)
   ) u_fifo (
      .clk      (clk),
      .rst_b    (rst_b),
      .inValid  (pushValid),
      .inReady  (pushReady),
      .inData   (pushWord),
      .outValid (popValid),
      .outReady (popReady),
      .outData  (popWord)
   );

   // Register is frozen while the strobe is low so the copied word is consistent
   assign popReady = !strobeLow;
   assign shiftNow = popValid && popReady;

   // First bit in ends in the top index, which is row fifteen column fifteen
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         shiftReg_r <= CSL_REG_RESET;
      end else if (shiftNow) begin
         shiftReg_r <= {shiftReg_r[CSL_BITS-2:0], popWord.dataBit};
      end
   end

   assign shiftDataOut = shiftReg_r[CSL_BITS-1];

   // Latches change only while the strobe is low
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         latch_r <= CSL_REG_RESET;
      end else if (strobeLow) begin
         latch_r <= shiftReg_r;
      end
   end

   // Index is row times sixteen plus column; one closes the switch
   assign switchClosed = latch_r;

   // Watchdogs on the controller's timing, reported as sticky levels
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         gapTmr_r     <= '0;
         armed_r      <= 1'b0;
         shiftTooSlow <= 1'b0;
      end else if (riseEdge) begin
         gapTmr_r <= '0;
         armed_r  <= 1'b1;
      end else if (strobeLow) begin
         armed_r  <= 1'b0;
      end else if (armed_r && gapTmr_r != GAP_LIMIT) begin
         gapTmr_r <= gapTmr_r + 1'b1;
      end else if (armed_r) begin
         shiftTooSlow <= 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         loadTmr_r <= '0;
         loading_r <= 1'b0;
         loadLate  <= 1'b0;
      end else if (riseEdge) begin
         loadTmr_r <= '0;
         loading_r <= 1'b1;
      end else if (loading_r && pinSync_r.loadStrobe_b && !pinPrev_r.loadStrobe_b) begin
         loading_r <= 1'b0;
      end else if (loading_r && loadTmr_r != LOAD_LIMIT) begin
         loadTmr_r <= loadTmr_r + 1'b1;
      end else if (loading_r) begin
         loadLate  <= 1'b1;
      end
   end

   sequence s_edgeSeen;
      riseEdge && !pending_r && pushReady && !strobeLow;
   endsequence

   sequence s_strobeFell;
      $fell(pinSync_r.loadStrobe_b) && !shiftNow;
   endsequence

   property p_edge_shifts;
      @(posedge clk) disable iff (!rst_b)
         s_edgeSeen |-> ##[1:9] shiftNow;
   endproperty
   a_edge_shifts: assert property (p_edge_shifts) else $error("edge not shifted");

   property p_shift_order;
      @(posedge clk) disable iff (!rst_b)
         shiftNow |=> shiftReg_r[0] == $past(popWord.dataBit)
                      && shiftReg_r[CSL_BITS-1:1] == $past(shiftReg_r[CSL_BITS-2:0]);
   endproperty
   a_shift_order: assert property (p_shift_order) else $error("bad shift order");

   property p_out_last;
      @(posedge clk) disable iff (!rst_b)
         shiftNow |=> shiftDataOut == $past(shiftReg_r[CSL_BITS-2]);
   endproperty
   a_out_last: assert property (p_out_last) else $error("output not last stage");

   property p_out_stage;
      @(posedge clk) disable iff (!rst_b)
         !shiftNow |=> $stable(shiftDataOut);
   endproperty
   a_out_stage: assert property (p_out_stage) else $error("output moved idle");

   property p_copy;
      @(posedge clk) disable iff (!rst_b)
         s_strobeFell |=> switchClosed == $past(shiftReg_r) ##1 $stable(switchClosed);
   endproperty
   a_copy: assert property (p_copy) else $error("latch copy wrong");

   property p_hold;
      @(posedge clk) disable iff (!rst_b)
         !strobeLow |=> $stable(switchClosed);
   endproperty
   a_hold: assert property (p_hold) else $error("latch changed without strobe");

   property p_noop;
      @(posedge clk) disable iff (!rst_b)
         !strobeLow && !pinSync_r.shiftClk && !popValid && !pending_r
            |=> $stable(shiftReg_r) && $stable(switchClosed);
   endproperty
   a_noop: assert property (p_noop) else $error("activity in idle state");

   property p_width;
      @(posedge clk) disable iff (!rst_b)
         strobeLow ##1 strobeLow |-> switchClosed == shiftReg_r;
   endproperty
   a_width: assert property (p_width) else $error("latch word mismatch");

   property p_closed;
      @(posedge clk) disable iff (!rst_b)
         strobeLow |=> switchClosed == $past(shiftReg_r);
   endproperty
   a_closed: assert property (p_closed) else $error("switch state wrong");
endmodule
`default_nettype wire

// ===== tb/csl_host.sv
// Purpose: Host controller model that shifts bits in and pulses the load strobe.
// Assumes: Each call starts 3 ns after a clk edge; one bit takes 80 ns.
// Notes: Serial clock idles low between frames; data inverts once hold time ends.
`default_nettype none
module csl_host
   import csl_pkg::*;
(
   output var logic shiftClk,
   output var logic shiftDataIn,
   output var logic loadStrobe_b
);
   timeunit 1ns;
   timeprecision 100ps;

   initial {shiftClk, shiftDataIn, loadStrobe_b} = CSL_PINS_IDLE;

   // 80 ns period stays far above the minimum shift rate
   // Data waits 10 ns so back-to-back bits never drive it twice in one step
   task automatic shift_bit(input logic b);
      #10 shiftDataIn = b;
      #30 shiftClk = 1'b1;
      #40 shiftClk = 1'b0;
      shiftDataIn = ~b;                     // No stale level after hold
   endtask

   task automatic set_strobe(input logic v);
      #60 loadStrobe_b = v;
   endtask

   // Strobe falls 60 ns into the call and stays low 40 ns, well inside the deadline
   task automatic pulse_load();
      set_strobe(1'b0);
      #40 loadStrobe_b = 1'b1;
      #30;
   endtask
endmodule
`default_nettype wire

// ===== tb/crosspoint_serial_loader_bench.sv
// Purpose: Self-checking bench for the crosspoint serial loader.
// Assumes: Small watchdog counts: gap 50 clk, load deadline 200 clk.
// Notes: expReg models the shift register; index 255 is the oldest bit.
`default_nettype none
module crosspoint_serial_loader_bench
   import csl_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;

   logic                clk = 1'b0;
   logic                rst_b = 1'b0;
   logic                shiftClk;
   logic                shiftDataIn;
   logic                loadStrobe_b;
   logic                shiftDataOut;
   logic                shiftTooSlow;
   logic                loadLate;
   logic [CSL_BITS-1:0] switchClosed;
   logic [CSL_BITS-1:0] expReg = '0;
   logic [CSL_BITS-1:0] held;
   int                  n_mismatch = 0;
   int                  total_checks = 0;

   always #5 clk = ~clk;

   csl_host i_csl_host (
      .shiftClk    (shiftClk),
      .shiftDataIn (shiftDataIn),
      .loadStrobe_b(loadStrobe_b)
   );

   csl_loader #(.SHIFT_GAP_CYC(50), .LOAD_MAX_CYC(200)) i_csl_loader (
      .clk         (clk),
      .rst_b       (rst_b),
      .shiftClk    (shiftClk),
      .shiftDataIn (shiftDataIn),
      .loadStrobe_b(loadStrobe_b),
      .shiftDataOut(shiftDataOut),
      .switchClosed(switchClosed),
      .shiftTooSlow(shiftTooSlow),
      .loadLate    (loadLate)
   );

   task automatic check(input string name, input logic [CSL_BITS-1:0] seen, exp);
      total_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // First bit is one, so a shift that never reaches the last stage shows up
   function automatic logic pat(input int k, input logic inv);
      return k[0] ^ k[5] ^ k[7] ^ ~inv;
   endfunction

   task automatic do_reset();
      @(posedge clk);
      #3 rst_b = 1'b0;
      repeat (4) @(posedge clk);
      #3 rst_b = 1'b1;
      expReg = '0;
   endtask

   task automatic send(input int n, input logic inv);
      for (int k = 0; k < n; k++) begin
         i_csl_host.shift_bit(pat(k, inv));
         expReg = {expReg[CSL_BITS-2:0], pat(k, inv)};
      end
   endtask

   task automatic t_load_latch();
      send(CSL_BITS, 1'b0);
      #60 check("latch before strobe", switchClosed, '0);
      check("last stage", shiftDataOut, pat(0, 1'b0));
      i_csl_host.pulse_load();
      #100 check("latched word", switchClosed, expReg);
      check("row15 col15", switchClosed[CSL_BITS-1], pat(0, 1'b0));
      check("row0 col0", switchClosed[0], pat(CSL_BITS-1, 1'b0));
      held = expReg;
      #2000 check("latch held", switchClosed, held);
   endtask

   task automatic t_cascade();
      for (int k = 0; k < 4; k++) begin
         send(1, 1'b1);
         #60 check("cascade out", shiftDataOut, expReg[CSL_BITS-1]);
         check("latch during shift", switchClosed, held);
      end
   endtask

   // Nine edges under a low strobe fill the buffer; none may be lost on release
   task automatic t_strobe_low_fill();
      i_csl_host.set_strobe(1'b0);
      held = expReg;
      send(9, 1'b1);
      check("copy while low", switchClosed, held);
      i_csl_host.set_strobe(1'b1);
      #100 i_csl_host.pulse_load();
      #100 check("drained word", switchClosed, expReg);
      check("slow flag idle", shiftTooSlow, 1'b0);
      check("late flag idle", loadLate, 1'b0);
   endtask

   task automatic t_watchdogs();
      send(1, 1'b0);
      #1000 send(1, 1'b0);
      #2500 check("slow flag", shiftTooSlow, 1'b1);
      check("late flag", loadLate, 1'b1);
      do_reset();
      #20 check("reset latch", switchClosed, '0);
      check("reset out", shiftDataOut, 1'b0);
      check("reset flags", {shiftTooSlow, loadLate}, 2'h0);
   endtask

   // Scenarios need about 30 us; a hang stops at the 200 us limit, well above that
   initial begin
      #200_000;
      n_mismatch++;
      end_of_test();
   end

   initial begin
      do_reset();
      t_load_latch();
      t_cascade();
      t_strobe_low_fill();
      t_watchdogs();
      end_of_test();
   end
endmodule
`default_nettype wire
